// ===== lvg_regs.svh
// Register numbers, reset values and timing counts of the low-voltage I/O control block
`ifndef LVG_REGS_SVH
`define LVG_REGS_SVH

`define LVG_REG_IO0       6'h21
`define LVG_REG_IO1       6'h22
`define LVG_REG_IO2       6'h23
`define LVG_REG_IO3       6'h24
`define LVG_NUM_PINS      4
`define LVG_ADDR_W        6
`define LVG_DATA_W        24
`define LVG_CTRL_W        16
`define LVG_CTRL_RESET    16'h3808
`define LVG_DIN_BIT       1
`define LVG_CLK_NS        25
`define LVG_TICK_NS       1000000
`define LVG_TICK_CYCLES   (`LVG_TICK_NS / `LVG_CLK_NS)
`define LVG_DEBOUNCE_MS_1    5'h0a
`define LVG_DEBOUNCE_MS_2    5'h14
`define LVG_DEBOUNCE_MS_3    5'h1e
`define LVG_DEBOUNCE_CNT_W   5

`endif

// ===== lvg_pkg.sv
// Types of the low-voltage I/O control block
package lvg_pkg;

  typedef enum logic [1:0] {
    LVG_DEBOUNCE_NONE = 2'h0,
    LVG_DEBOUNCE_10MS = 2'h1,
    LVG_DEBOUNCE_20MS = 2'h2,
    LVG_DEBOUNCE_30MS = 2'h3
  } lvg_debounce_type;

  typedef enum logic [1:0] {
    LVG_EDGE_NONE = 2'h0,
    LVG_EDGE_FALL = 2'h1,
    LVG_EDGE_BOTH = 2'h3,
    LVG_EDGE_RISE = 2'h2
  } lvg_edge_type;

  typedef struct packed {
    logic [1:0]       slew;
    logic [1:0]       pull_sel;
    logic             pull_en;
    logic             drive;
    logic             open_drain;
    logic             keep;
    lvg_edge_type     irq_edge;
    lvg_debounce_type debounce;
    logic             hysteresis;
    logic             dout;
    logic             din;
    logic             dir;
  } lvg_ctrl_type;

  typedef struct packed {
    logic       out;
    logic       oe;
    logic       hysteresis;
    logic       keep;
    logic       drive;
    logic       pull_en;
    logic [1:0] pull_sel;
    logic [1:0] slew;
  } lvg_pad_type;

endpackage : lvg_pkg

// ===== lvg_pin.sv
// Debounce filter and edge event for one low-voltage pin
`timescale 1ns/1ps
`include "lvg_regs.svh"
module lvg_pin (
  input  wire logic          i_clk,
  input  wire logic          i_sys_rst,
  input  wire logic          i_tick,
  input  wire logic          i_raw,
  input  lvg_pkg::lvg_debounce_type i_debounce,
  input  lvg_pkg::lvg_edge_type     i_edge,
  output logic               o_level,
  output logic               o_event
);
  import lvg_pkg::*;

  logic [`LVG_DEBOUNCE_CNT_W-1:0] cnt_q;
  logic [`LVG_DEBOUNCE_CNT_W-1:0] cnt_d;
  logic [`LVG_DEBOUNCE_CNT_W-1:0] limit;
  logic                       level_q;
  logic                       level_d;
  logic                       prev_q;
  logic                       armed_q;
  logic                       event_q;
  wire                        differs = i_raw != level_q;
  wire                        expired = (cnt_q + 5'h01) >= limit;
  wire                        rise    = level_q & ~prev_q;
  wire                        fall    = ~level_q & prev_q;
  wire                        hit_d   = (rise & i_edge[1]) | (fall & i_edge[0]);

  // Stable time in millisecond ticks
  assign limit = (i_debounce == LVG_DEBOUNCE_10MS) ? `LVG_DEBOUNCE_MS_1 :
                 (i_debounce == LVG_DEBOUNCE_20MS) ? `LVG_DEBOUNCE_MS_2 : `LVG_DEBOUNCE_MS_3;

  always_comb begin
    level_d = level_q;
    cnt_d   = cnt_q;
    if (i_debounce == LVG_DEBOUNCE_NONE) begin
      level_d = i_raw;
      cnt_d   = '0;
    end else if (!differs) begin
      cnt_d = '0;
    end else if (i_tick) begin
      if (expired) begin
        level_d = i_raw;
        cnt_d   = '0;
      end else begin
        cnt_d = cnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q   <= '0;
      level_q <= 1'b0;
      prev_q  <= 1'b0;
      armed_q <= 1'b0;
      event_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      level_q <= level_d;
      // First level taken after reset is not an edge
      prev_q  <= armed_q ? level_q : level_d;
      armed_q <= 1'b1;
      event_q <= hit_d;
    end
  end

  assign o_level = level_q;
  assign o_event = event_q;

endmodule : lvg_pin

// ===== lvg_top.sv
// Four low-voltage I/O pins with their control registers
`timescale 1ns/1ps
`include "lvg_regs.svh"
module lvg_top #(
  parameter int TICK_CYCLES = `LVG_TICK_CYCLES
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_sys_rst,
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  input  wire logic [`LVG_ADDR_W-1:0] i_reg_addr,
  input  wire logic [`LVG_DATA_W-1:0] i_reg_wdata,
  output logic      [`LVG_DATA_W-1:0] o_reg_rdata,
  input  wire logic [`LVG_NUM_PINS-1:0] i_pad_in,
  output lvg_pkg::lvg_pad_type [`LVG_NUM_PINS-1:0] o_pad,
  output logic      [`LVG_NUM_PINS-1:0] o_irq_event
);
  import lvg_pkg::*;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick divider

  logic [15:0] tick_cnt_q;
  logic        tick_q;
  wire         tick_wrap = tick_cnt_q == TICK_LAST;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_cnt_q <= tick_wrap ? 16'h0000 : tick_cnt_q + 16'h0001;
      tick_q     <= tick_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and pads

  lvg_ctrl_type                    ctrl_q [`LVG_NUM_PINS];
  logic [`LVG_NUM_PINS-1:0]        hit;
  logic [`LVG_NUM_PINS-1:0]        level;
  logic [`LVG_DATA_W-1:0]          view   [`LVG_NUM_PINS];
  logic [`LVG_DATA_W-1:0]          rdata_q;
  logic [`LVG_DATA_W-1:0]          rdata_d;
  wire  lvg_ctrl_type              wr_ctrl = lvg_ctrl_type'(i_reg_wdata[`LVG_CTRL_W-1:0]);

  genvar g;
  generate
    for (g = 0; g < `LVG_NUM_PINS; g++) begin : g_pin
      assign hit[g] = i_reg_addr == (`LVG_REG_IO0 + 6'(g));

      always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          ctrl_q[g] <= lvg_ctrl_type'(`LVG_CTRL_RESET);
        end else if (i_reg_wr && hit[g]) begin
          ctrl_q[g] <= wr_ctrl;
        end
      end

      lvg_pin i_lvg_pin (
        .i_clk      (i_clk),
        .i_sys_rst  (i_sys_rst),
        .i_tick     (tick_q),
        .i_raw      (i_pad_in[g]),
        .i_debounce (ctrl_q[g].debounce),
        .i_edge     (ctrl_q[g].irq_edge),
        .o_level    (level[g]),
        .o_event    (o_irq_event[g])
      );

      // Stored input-state bit is never shown; the live level is
      assign view[g] = {8'h00, ctrl_q[g][`LVG_CTRL_W-1:2], level[g], ctrl_q[g].dir};

      // Open drain drives only while the output level is low
      assign o_pad[g].oe         = ctrl_q[g].dir & ~(ctrl_q[g].open_drain & ctrl_q[g].dout);
      assign o_pad[g].out        = ctrl_q[g].dout & ~ctrl_q[g].open_drain;
      assign o_pad[g].hysteresis = ctrl_q[g].hysteresis;
      assign o_pad[g].keep       = ctrl_q[g].keep;
      assign o_pad[g].drive      = ctrl_q[g].drive;
      assign o_pad[g].pull_en    = ctrl_q[g].pull_en;
      assign o_pad[g].pull_sel   = ctrl_q[g].pull_sel;
      assign o_pad[g].slew       = ctrl_q[g].slew;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read port, one cycle latency, unmapped numbers read zero

  always_comb begin
    rdata_d = '0;
    for (int i = 0; i < `LVG_NUM_PINS; i++) begin
      if (hit[i]) begin
        rdata_d = view[i];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_q <= '0;
    end else if (i_reg_rd) begin
      rdata_q <= rdata_d;
    end
  end

  assign o_reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic out_of_rst_q;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      out_of_rst_q <= 1'b0;
    end else begin
      out_of_rst_q <= 1'b1;
    end
  end

  chk_reset_value : assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(out_of_rst_q) && !$past(i_reg_wr) |->
      ctrl_q[0] == lvg_ctrl_type'(`LVG_CTRL_RESET) && ctrl_q[3] == lvg_ctrl_type'(`LVG_CTRL_RESET))
    else $error("control fields not at default after reset");

  chk_write_stores : assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_reg_wr && i_reg_addr == `LVG_REG_IO2 |=> ctrl_q[2] == $past(wr_ctrl))
    else $error("write to third pin register not stored");

  chk_reserved_zero : assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_reg_rd |=> o_reg_rdata[`LVG_DATA_W-1:`LVG_CTRL_W] == 8'h00)
    else $error("reserved bits read nonzero");

  chk_unmapped_zero : assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_reg_rd && hit == '0 |=> o_reg_rdata == '0)
    else $error("unmapped register number reads nonzero");

  chk_din_level : assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_reg_rd && hit[1] |=> o_reg_rdata[`LVG_DIN_BIT] == $past(level[1]))
    else $error("input state bit differs from pin level");

  chk_input_float : assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !ctrl_q[0].dir |-> !o_pad[0].oe)
    else $error("input pin is driven");

  chk_push_pull : assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ctrl_q[1].dir && !ctrl_q[1].open_drain |-> o_pad[1].oe && o_pad[1].out == ctrl_q[1].dout)
    else $error("push-pull output does not follow level bit");

  chk_open_drain : assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ctrl_q[2].open_drain && o_pad[2].oe |-> !o_pad[2].out && !ctrl_q[2].dout)
    else $error("open-drain output drives high");

  chk_pad_attrs : assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_pad[3].drive == ctrl_q[3].drive && o_pad[3].slew == ctrl_q[3].slew &&
      o_pad[3].pull_sel == ctrl_q[3].pull_sel && o_pad[3].hysteresis == ctrl_q[3].hysteresis)
    else $error("pad attributes differ from control fields");

  chk_no_debounce : assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (out_of_rst_q && ctrl_q[0].debounce == LVG_DEBOUNCE_NONE) [*2] ##0 $stable(i_pad_in[0]) |->
      level[0] == i_pad_in[0])
    else $error("undebounced level lags the pin");

  chk_event_edge : assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_irq_event[1] |-> $past(level[1], 2) != $past(level[1]) &&
      ($past(level[1]) ? $past(ctrl_q[1].irq_edge[1]) : $past(ctrl_q[1].irq_edge[0])))
    else $error("event without a selected edge");

  chk_event_pulse : assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_irq_event[0] && ctrl_q[0].irq_edge != LVG_EDGE_BOTH |=> !o_irq_event[0])
    else $error("single-edge event longer than one cycle");

  cov_write : cover property (@(posedge i_clk) disable iff (i_sys_rst)
    i_reg_wr && hit[0]);
  cov_event : cover property (@(posedge i_clk) disable iff (i_sys_rst)
    o_irq_event[2]);
  cov_od_low : cover property (@(posedge i_clk) disable iff (i_sys_rst)
    ctrl_q[3].open_drain && o_pad[3].oe);
  cov_tick : cover property (@(posedge i_clk) disable iff (i_sys_rst)
    tick_q);

endmodule : lvg_top

// ===== lvg_board_model.sv
// Board-side model of the four low-voltage pins
`timescale 1ns/1ps
`include "lvg_regs.svh"
module lvg_board_model (
  input  wire logic                                i_clk,
  input  lvg_pkg::lvg_pad_type [`LVG_NUM_PINS-1:0] i_pad,
  input  wire logic [`LVG_NUM_PINS-1:0]            i_ext_en,
  input  wire logic [`LVG_NUM_PINS-1:0]            i_ext_val,
  output logic      [`LVG_NUM_PINS-1:0]            o_level
);
  import lvg_pkg::*;
  logic [`LVG_NUM_PINS-1:0] last_q = '0;
  always @(posedge i_clk) begin
    last_q <= o_level;
  end
  // Floating pin without keeper flips so a stale level never looks valid
  always_comb begin
    for (int p = 0; p < `LVG_NUM_PINS; p++) begin
      if (i_pad[p].oe) o_level[p] = i_pad[p].out;
      else if (i_ext_en[p]) o_level[p] = i_ext_val[p];
      else if (i_pad[p].pull_en) o_level[p] = i_pad[p].pull_sel[1];
      else if (i_pad[p].keep) o_level[p] = last_q[p];
      else o_level[p] = ~last_q[p];
    end
  end
endmodule : lvg_board_model

// ===== test_low_voltage_gpio_control.sv
// Self-checking testbench of the low-voltage I/O control block
`timescale 1ns/1ps
`include "lvg_regs.svh"
module test_low_voltage_gpio_control;
  import lvg_pkg::*;
  localparam int TICK = 4;
  logic                            clk = 1'b0;
  logic                            rst = 1'b1;
  logic                            wr = 1'b0;
  logic                            rd = 1'b0;
  logic [`LVG_ADDR_W-1:0]          addr = '0;
  logic [`LVG_DATA_W-1:0]          wdata = '0;
  logic [`LVG_DATA_W-1:0]          rdata;
  logic [`LVG_NUM_PINS-1:0]        pin;
  logic [`LVG_NUM_PINS-1:0]        ev;
  logic [`LVG_NUM_PINS-1:0]        ext_en = '0;
  logic [`LVG_NUM_PINS-1:0]        ext_val = '0;
  lvg_pad_type [`LVG_NUM_PINS-1:0] pad;
  int                              fail_count = 0;
  int                              num_checks = 0;
  int                              ev_cnt = 0;
  int                              stray_cnt = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (ev[0] === 1'b1) ev_cnt++;
  // Pins 2 and 3 have an edge selected only in t_fields, where their level does not change
  always @(posedge clk) if (!rst && ev[3:2] !== 2'b00) stray_cnt++;
  lvg_top #(.TICK_CYCLES(TICK)) i_lvg_top (.i_clk(clk), .i_sys_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_pad_in(pin), .o_pad(pad), .o_irq_event(ev));
  lvg_board_model i_lvg_board_model (.i_clk(clk), .i_pad(pad), .i_ext_en(ext_en), .i_ext_val(ext_val),
    .o_level(pin));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] got, input logic [23:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check
  task automatic reg_wr(input logic [5:0] a, input logic [23:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : reg_wr
  task automatic reg_rd(input logic [5:0] a, output logic [23:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [23:0] d;
    repeat (3) @(posedge clk);
    for (int p = 0; p < 4; p++) begin
      reg_rd(6'(`LVG_REG_IO0 + p), d);
      check(d, 24'h00380a, "reset value");
      check(24'(pad[p]), 24'h09c, "reset pad");
    end
    reg_wr(6'h25, 24'hffffff);
    reg_rd(6'h25, d);
    check(d, 24'h0, "unmapped read");
    reg_rd(6'h20, d);
    check(d, 24'h0, "unmapped read");
    $display("test reset done");
  endtask : t_reset
  task automatic t_fields();
    logic [23:0] d;
    for (int p = 0; p < 4; p++) begin
      reg_wr(6'(`LVG_REG_IO0 + p), 24'hffffff);
      reg_rd(6'(`LVG_REG_IO0 + p), d);
      check(d, 24'h00ffff, "all ones");
      check(24'(pad[p]), 24'h0ff, "all ones pad");
    end
    $display("test fields done");
  endtask : t_fields
  task automatic t_output();
    logic [23:0] d;
    reg_wr(`LVG_REG_IO2, 24'h003805);
    check({pad[2].oe, pad[2].out}, 2'b11, "drive high");
    reg_wr(`LVG_REG_IO2, 24'h003801);
    check({pad[2].oe, pad[2].out}, 2'b10, "drive low");
    repeat (3) @(posedge clk);
    reg_rd(`LVG_REG_IO2, d);
    check(d, 24'h003801, "low readback");
    reg_wr(`LVG_REG_IO2, 24'h003a05);
    check(pad[2].oe, 1'b0, "od high released");
    repeat (3) @(posedge clk);
    reg_rd(`LVG_REG_IO2, d);
    check(d, 24'h003a07, "od pulled up");
    reg_wr(`LVG_REG_IO2, 24'h003a01);
    check({pad[2].oe, pad[2].out}, 2'b10, "od low");
    reg_wr(`LVG_REG_IO2, 24'h003804);
    check(pad[2].oe, 1'b0, "input released");
    $display("test output done");
  endtask : t_output
  task automatic t_edges();
    int exp [4] = '{0, 2, 2, 4};
    ext_en[0] <= 1'b1;
    ext_val[0] <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      reg_wr(`LVG_REG_IO0, 24'(24'h003808 | (c << 6)));
      repeat (3) @(posedge clk);
      #1 ev_cnt = 0;
      repeat (2) begin
        @(posedge clk) ext_val[0] <= 1'b0;
        repeat (4) @(posedge clk);
        ext_val[0] <= 1'b1;
        repeat (4) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      check(ev_cnt, exp[c], "edge events");
    end
    $display("test edges done");
  endtask : t_edges
  task automatic t_debounce();
    int n;
    ext_en[1] <= 1'b1;
    ext_val[1] <= 1'b0;
    for (int c = 1; c < 4; c++) begin
      reg_wr(`LVG_REG_IO1, 24'h003808);
      repeat (3) @(posedge clk);
      reg_wr(`LVG_REG_IO1, 24'(24'h003888 | (c << 4)));
      @(posedge clk) ext_val[1] <= 1'b1;
      n = 0;
      while (ev[1] !== 1'b1 && n < 200) begin
        @(posedge clk);
        n++;
      end
      check(n >= (10 * c - 1) * TICK && n <= 10 * c * TICK + 3, 1'b1, "debounce time");
      ext_val[1] <= 1'b0;
    end
    check(stray_cnt, 24'h0, "stray events");
    $display("test debounce done");
  endtask : t_debounce
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_fields();
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_output();
    t_edges();
    t_debounce();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("mismatch t=%0t watchdog expired", $time);
    conclude();
  end
endmodule : test_low_voltage_gpio_control
